// *** logic/bank_ctrl_copy.sv ***
// One subsystem's copy of the bank-switch control register.
`timescale 1ns/100ps
module bank_ctrl_copy (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_lanes,
	output logic      [15:0] value,
	output logic             ipi_pulse
);
	logic [15:0] lane_mask;
	logic [15:0] merged;

	// Byte lanes select which halves change; reserved bits never change.
	always_comb begin
		lane_mask = {{8{wr_lanes[1]}}, {8{wr_lanes[0]}}} & bank_switch_pkg::CTRL_WMASK;
		merged    = (value & ~lane_mask) | (wr_data & lane_mask); // [RULE6]
	end

	// Register storage; bits 15-12 and 11 come up set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value <= bank_switch_pkg::CTRL_RESET; // [RULE3] [RULE5] [RULE8] [RULE9]
		end else if (wr_en) begin
			value <= merged;
		end
	end

	// A new interrupt goes out only on a 0-to-1 change, so the bit must be cleared first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ipi_pulse <= 1'b0;
		end else begin
			ipi_pulse <= wr_en && merged[bank_switch_pkg::IPI_BIT]
				&& !value[bank_switch_pkg::IPI_BIT]; // [RULE7]
		end
	end

	AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
		(value & ~bank_switch_pkg::CTRL_WMASK) == 16'h0000)
		else $error("Reserved control bits changed.");
	AST_RESET_VALUE: assert property (@(posedge aclk) // [RULE3]
		$rose(aresetn) |-> value == bank_switch_pkg::CTRL_RESET)
		else $error("Control register reset value wrong.");
	AST_IPI_NEEDS_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
		ipi_pulse |-> value[bank_switch_pkg::IPI_BIT] && !$past(value[bank_switch_pkg::IPI_BIT]))
		else $error("Interrupt resent without clearing.");
endmodule : bank_ctrl_copy

// *** logic/bank_switch_bus_control.sv ***
// Bank-switch external bus control with AXI4-Lite registers.
// Operation
// RULE1: Add one bus cycle when an access crosses a bank inside program or data space.
// RULE2: Add one cycle moving program to data space or between program pages; code adds it for a space change only with bit 11, two reads.
// RULE3: Bits 15-12 mask upper address bits for bank compare; reset 1111 gives 4K.
// RULE4: Bank size spans 4K to 64K words through the mask field.
// RULE5: Bit 11 set adds a cycle between program and data reads.
// RULE6: Reserved bits 10-9, 7-3, 1 read zero and ignore writes.
// RULE7: Writing 1 to bit 8 interrupts the other side; clear before resending.
// RULE8: Bit 2 enables the bus holder keeping undriven data pins at last level.
// RULE9: Bit 0 turns the bus off after the current cycle completes.
// RULE10: While bus is off, mode configuration bit changes are blocked; the code only raises cfg_lock_a/cfg_lock_b and still accepts the writes.
// RULE11: Each subsystem has a copy; the granted one governs the interface.
// RULE12: 64K-word I/O space via port read and write, with I/O strobe asserted.
// RULE13: Subsystem select shows which subsystem performs the I/O access.
// RULE14: Detect a bank crossing by comparing masked upper bits with previous access.
`timescale 1ns/100ps
module bank_switch_bus_control (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	// Arbitration and access request from the cores.
	input  wire logic        grant_b,
	input  wire logic        acc_valid,
	output logic             acc_ready,
	input  wire logic [1:0]  acc_space,
	input  wire logic        acc_write,
	input  wire logic [15:0] acc_addr,
	input  wire logic [6:0]  acc_page,
	input  wire logic [15:0] acc_wdata,
	output logic [15:0]      acc_rdata,
	// Interprocessor interrupts and configuration locks.
	output logic             interprocessor_irq_to_a,
	output logic             interprocessor_irq_to_b,
	output logic             cfg_lock_a,
	output logic             cfg_lock_b,
	// External parallel bus pins.
	output logic [15:0]      ext_addr,
	output logic             ext_strobe_n,
	output logic             ext_write,
	output logic             io_space_strobe_n,
	output logic             subsystem_select,
	input  wire logic [15:0] parallel_data_pins_in,
	output logic [15:0]      parallel_data_pins_out,
	output logic             parallel_data_pins_oe,
	output logic             bus_holder_enable,
	output logic [15:0]      holder_level
);
	typedef enum {ST_IDLE, ST_GAP, ST_XFER} seq_state_t;

	// Register decode shared by the read and write paths.
	function automatic logic [2:0] reg_sel(input logic [7:0] addr);
		if (addr[1:0] != 2'h0 || addr >= bank_switch_pkg::OFS_LIMIT) begin
			reg_sel = 3'h7;
		end else begin
			reg_sel = {1'b0, addr[3:2]} | {addr[4], 2'h0};
		end
	endfunction : reg_sel

	////////////////////////////////////////////////////////////////////////////
	localparam int IRQ_W_L = bank_switch_pkg::IRQ_W;
	logic              wr_go;
	logic [2:0]        wsel;
	logic [1:0]        ctrl_wr;
	logic [15:0]       ctrl [2];
	logic [1:0]        ipi;
	logic [IRQ_W_L-1:0] status;
	logic [IRQ_W_L-1:0] enable;

	// Both write channels are taken together in one edge.
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign wsel          = reg_sel(s_axi_awaddr);
	assign ctrl_wr[0]    = wr_go && wsel == 3'h0;
	assign ctrl_wr[1]    = wr_go && wsel == 3'h1;

	// One register copy for each subsystem.
	generate
		for (genvar i = 0; i < 2; i++) begin : g_copy
			bank_ctrl_copy u_copy (
				.aclk      (aclk),
				.aresetn   (aresetn),
				.wr_en     (ctrl_wr[i]),
				.wr_data   (s_axi_wdata[15:0]),
				.wr_lanes  (s_axi_wstrb[1:0]),
				.value     (ctrl[i]),
				.ipi_pulse (ipi[i])
			); // [RULE11]
		end
	endgenerate

	// Subsystem A's write interrupts B and the reverse.
	assign interprocessor_irq_to_b = ipi[0]; // [RULE7]
	assign interprocessor_irq_to_a = ipi[1]; // [RULE7]

	// Each side's lock output follows its own bus-off bit; the mode bits can still be written.
	assign cfg_lock_a = ctrl[0][bank_switch_pkg::OFF_BIT]; // [RULE10]
	assign cfg_lock_b = ctrl[1][bank_switch_pkg::OFF_BIT]; // [RULE10]

	// Write response one cycle after the write is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= bank_switch_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wsel == 3'h7) ? bank_switch_pkg::RESP_SLVERR
				: bank_switch_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Sticky status: a new event wins over a clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
		end else if (wr_go && wsel == 3'h3 && s_axi_wstrb[0]) begin
			status <= (status & ~s_axi_wdata[IRQ_W_L-1:0]) | {ipi[1], ipi[0]};
		end else begin
			status <= status | {ipi[1], ipi[0]};
		end
	end

	// Interrupt enable register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable <= '0;
		end else if (wr_go && wsel == 3'h4 && s_axi_wstrb[0]) begin
			enable <= s_axi_wdata[IRQ_W_L-1:0];
		end
	end

	assign irq = |(status & enable);

	////////////////////////////////////////////////////////////////////////////
	logic [2:0] rsel;

	assign s_axi_arready = !s_axi_rvalid;
	assign rsel          = reg_sel(s_axi_araddr);

	// Read data is registered; unmapped addresses return zero with an error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= bank_switch_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= bank_switch_pkg::RESP_OKAY;
			case (rsel)
				3'h0: s_axi_rdata <= {16'h0000, ctrl[0]};
				3'h1: s_axi_rdata <= {16'h0000, ctrl[1]};
				3'h2: s_axi_rdata <= {30'h0, status};
				3'h4: s_axi_rdata <= {30'h0, enable};
				3'h3: s_axi_rdata <= 32'h0000_0000;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= bank_switch_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	seq_state_t  state;
	logic [15:0] gov;
	logic [3:0]  cmp_mask;
	logic        bus_off;
	logic        prev_ok;
	logic [1:0]  prev_space;
	logic        prev_write;
	logic [3:0]  prev_hi;
	logic [6:0]  prev_page;
	logic        bank_cross;
	logic        page_chg;
	logic        space_gap;
	logic        need_gap;
	logic        start;
	logic [15:0] pin_meta;
	logic [15:0] pin_sync;

	// The granted subsystem's copy steers the shared interface.
	assign gov      = grant_b ? ctrl[1] : ctrl[0]; // [RULE11]
	assign cmp_mask = gov[bank_switch_pkg::CMP_MSB:bank_switch_pkg::CMP_LSB]; // [RULE3] [RULE4]
	assign bus_off  = gov[bank_switch_pkg::OFF_BIT];

	// Masked upper bits against the previous access of the same space.
	assign bank_cross = prev_ok && acc_space == prev_space && acc_space != bank_switch_pkg::SPACE_IO
		&& ((acc_addr[15:12] ^ prev_hi) & cmp_mask) != 4'h0; // [RULE1] [RULE14]
	assign page_chg   = prev_ok && acc_space == bank_switch_pkg::SPACE_PROG
		&& prev_space == bank_switch_pkg::SPACE_PROG && acc_page != prev_page; // [RULE2]
	// Program/data turnaround, gated by the gap bit; applies only between two reads.
	assign space_gap  = prev_ok && gov[bank_switch_pkg::GAP_BIT] && !acc_write && !prev_write
		&& acc_space != prev_space && acc_space != bank_switch_pkg::SPACE_IO
		&& prev_space != bank_switch_pkg::SPACE_IO; // [RULE2] [RULE5]
	assign need_gap   = bank_cross || page_chg || space_gap;
	assign start      = state == ST_IDLE && acc_valid && !bus_off; // [RULE9]
	assign acc_ready  = state == ST_XFER;

	// Access sequencer; the idle cycle lets the old driver release the bus.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: if (start) begin
					state <= need_gap ? ST_GAP : ST_XFER; // [RULE1] [RULE2]
				end
				ST_GAP:  state <= ST_XFER;
				ST_XFER: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// History of the last completed access.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_ok    <= 1'b0;
			prev_space <= bank_switch_pkg::SPACE_PROG;
			prev_write <= 1'b0;
			prev_hi    <= 4'h0;
			prev_page  <= 7'h00;
		end else if (state == ST_XFER) begin
			prev_ok    <= 1'b1;
			prev_space <= acc_space;
			prev_write <= acc_write;
			prev_hi    <= acc_addr[15:12]; // [RULE14]
			prev_page  <= acc_page;
		end
	end

	// Pin outputs other than subsystem_select go live for the transfer cycle and idle otherwise.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_addr               <= 16'h0000;
			ext_strobe_n           <= 1'b1;
			ext_write              <= 1'b0;
			io_space_strobe_n      <= 1'b1;
			subsystem_select       <= 1'b0;
			parallel_data_pins_out <= 16'h0000;
			parallel_data_pins_oe  <= 1'b0;
		end else if ((start && !need_gap) || state == ST_GAP) begin
			ext_addr               <= acc_addr;
			ext_strobe_n           <= acc_space == bank_switch_pkg::SPACE_IO;
			ext_write              <= acc_write;
			io_space_strobe_n      <= acc_space != bank_switch_pkg::SPACE_IO; // [RULE12]
			subsystem_select       <= grant_b; // [RULE13]
			parallel_data_pins_out <= acc_wdata;
			parallel_data_pins_oe  <= acc_write;
		end else begin
			ext_addr               <= 16'h0000; // [RULE9]
			ext_strobe_n           <= 1'b1;
			ext_write              <= 1'b0;
			io_space_strobe_n      <= 1'b1;
			parallel_data_pins_out <= 16'h0000;
			parallel_data_pins_oe  <= 1'b0;
		end
	end

	// Data pins come from outside the clock domain and pass two flops.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= 16'h0000;
			pin_sync <= 16'h0000;
		end else begin
			pin_meta <= parallel_data_pins_in;
			pin_sync <= pin_meta;
		end
	end

	// Read data and holder level; the holder keeps the last seen bus value.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_rdata         <= 16'h0000;
			holder_level      <= 16'h0000;
			bus_holder_enable <= 1'b0;
		end else begin
			bus_holder_enable <= gov[bank_switch_pkg::HOLD_BIT]; // [RULE8]
			holder_level      <= parallel_data_pins_oe ? parallel_data_pins_out : pin_sync; // [RULE8]
			if (state == ST_XFER) begin
				acc_rdata <= pin_sync;
			end
		end
	end

	AST_BANK_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
		start && bank_cross |=> state == ST_GAP ##1 state == ST_XFER)
		else $error("Bank crossing did not insert one cycle.");
	AST_PAGE_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
		start && page_chg |=> state == ST_GAP)
		else $error("Program page change did not insert a cycle.");
	AST_NO_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
		start && !bank_cross && !page_chg && !gov[11] |=> state == ST_XFER)
		else $error("Cycle inserted without cause.");
	AST_IO_STROBE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
		state == ST_XFER && acc_space == bank_switch_pkg::SPACE_IO |-> !io_space_strobe_n
		&& ext_strobe_n && ext_addr == acc_addr)
		else $error("I/O strobe missing during I/O transfer.");
	AST_SELECT: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
		start |=> ##[0:1] (state == ST_XFER && subsystem_select == $past(grant_b, 1)) or
		(state == ST_GAP ##1 subsystem_select == $past(grant_b, 1)))
		else $error("Subsystem select wrong for transfer.");
	AST_BUS_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
		state == ST_IDLE && bus_off |=> state == ST_IDLE && ext_strobe_n && io_space_strobe_n
		&& !parallel_data_pins_oe)
		else $error("Bus active while switched off.");
	AST_IRQ_STICKY: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
		ipi[0] |=> status[0] && (enable[0] -> irq))
		else $error("Interprocessor event not latched.");
	AST_GOVERN: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
		grant_b && ctrl[1][0] && !ctrl[0][0] && state == ST_IDLE |=> state == ST_IDLE)
		else $error("Wrong subsystem copy governs the bus.");
endmodule : bank_switch_bus_control

// *** logic/bank_switch_pkg.sv ***
// Shared constants for the bank-switch external bus control block.
package bank_switch_pkg;
	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] OFS_CTRL_A     = 8'h00;
	localparam logic [7:0] OFS_CTRL_B     = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFS_LIMIT      = 8'h14;
	// Control register field positions.
	localparam int CMP_MSB   = 15;
	localparam int CMP_LSB   = 12;
	localparam int GAP_BIT   = 11;
	localparam int IPI_BIT   = 8;
	localparam int HOLD_BIT  = 2;
	localparam int OFF_BIT   = 0;
	// Reset value and the bits that software may change.
	localparam logic [15:0] CTRL_RESET = 16'hF800;
	localparam logic [15:0] CTRL_WMASK = 16'hF905;
	// Interrupt status bit positions.
	localparam int IRQ_IPI_A = 0;
	localparam int IRQ_IPI_B = 1;
	localparam int IRQ_W     = 2;
	// Access space codes on the request port.
	localparam logic [1:0] SPACE_PROG = 2'h0;
	localparam logic [1:0] SPACE_DATA = 2'h1;
	localparam logic [1:0] SPACE_IO   = 2'h2;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bank_switch_pkg

// *** tb/bank_switch_bus_control_tb_top.sv ***
// Self-checking bench for the bank-switch external bus control block.
`timescale 1ns/100ps
module bank_switch_bus_control_tb_top;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq, acc_ready, to_a, to_b;
	logic        lock_a, lock_b, strobe_n, ext_write, io_n, select, pins_oe, holder_en;
	logic [1:0]  bresp, rresp, resp, prev_sp;
	logic [15:0] acc_rdata, ext_addr, pins_in, pins_out, holder_level, prev_ad;
	logic        grant_b = 1'h0, acc_valid = 1'h0, acc_write = 1'h0, prev_ok = 1'h0, prev_wr;
	logic [1:0]  acc_space = 2'h0;
	logic [15:0] acc_addr = 16'h0, acc_wdata = 16'h0, ctrl_a = 16'hF800, ctrl_b = 16'hF800;
	logic [6:0]  acc_page = 7'h00, prev_pg;
	int          fail_count = 0, checks = 0, seed = 10241, ipi_a = 0, ipi_b = 0, k, ka;
	logic        g;

	bank_switch_bus_control u_bank_switch_bus_control (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
		.grant_b(grant_b), .acc_valid(acc_valid), .acc_ready(acc_ready),
		.acc_space(acc_space), .acc_write(acc_write), .acc_addr(acc_addr),
		.acc_page(acc_page), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
		.interprocessor_irq_to_a(to_a), .interprocessor_irq_to_b(to_b),
		.cfg_lock_a(lock_a), .cfg_lock_b(lock_b), .ext_addr(ext_addr),
		.ext_strobe_n(strobe_n), .ext_write(ext_write), .io_space_strobe_n(io_n),
		.subsystem_select(select), .parallel_data_pins_in(pins_in),
		.parallel_data_pins_out(pins_out), .parallel_data_pins_oe(pins_oe),
		.bus_holder_enable(holder_en), .holder_level(holder_level)
	);

	ext_bus_model u_ext_bus_model (
		.aclk(aclk), .ext_strobe_n(strobe_n), .io_space_strobe_n(io_n),
		.ext_write(ext_write), .ext_addr(ext_addr), .data_out(pins_in)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Free-running clock of 8 ns.
	initial forever #4 aclk = ~aclk;

	// Interrupt pulses are counted so that a missing or doubled pulse shows.
	always @(posedge aclk) begin
		ipi_a <= ipi_a + (to_a === 1'h1);
		ipi_b <= ipi_b + (to_b === 1'h1);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Readies are sampled at the falling edge, so the handshake edge is the next rising one.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(negedge aclk); while (!(awready === 1'h1 && wready === 1'h1));
		@(posedge aclk);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(negedge aclk); while (bvalid !== 1'h1);
		resp = bresp;
		@(posedge aclk);
		bready <= 1'h0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(negedge aclk); while (arready !== 1'h1);
		@(posedge aclk);
		arvalid <= 1'h0;
		do @(negedge aclk); while (rvalid !== 1'h1);
		rd = rdata;
		resp = rresp;
		@(posedge aclk);
		rready <= 1'h0;
	endtask : axi_read

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		axi_read(a);
		check("read data", rd, e);
		check("read response", resp, r);
	endtask : rd_chk

	// Writes one control copy and keeps the bench's own image of it.
	task automatic wr_ctrl(input logic b, input logic [15:0] v);
		axi_write(b ? bank_switch_pkg::OFS_CTRL_B : bank_switch_pkg::OFS_CTRL_A, {16'h0, v});
		check("ctrl write response", resp, bank_switch_pkg::RESP_OKAY);
		if (b) ctrl_b = v & 16'hF905;
		else ctrl_a = v & 16'hF905;
	endtask : wr_ctrl

	// Gap expectation: bank crossing, page change, or read turn-around when enabled.
	function automatic logic [31:0] exp_lat(input logic [1:0] sp, input logic wr,
			input logic [15:0] ad, input logic [6:0] pg);
		logic [15:0] c;
		logic        gap;
		c = grant_b ? ctrl_b : ctrl_a;
		gap = sp == prev_sp && sp != 2'h2 && ((ad[15:12] ^ prev_ad[15:12]) & c[15:12]) != 4'h0;
		gap |= sp == 2'h0 && prev_sp == 2'h0 && pg != prev_pg;
		gap |= c[11] && !wr && !prev_wr && sp != prev_sp && sp != 2'h2 && prev_sp != 2'h2;
		return (prev_ok && gap) ? 32'h3 : 32'h2;
	endfunction : exp_lat

	// One external access; the pins are checked in the cycle that acc_ready stands.
	task automatic access(input logic [1:0] sp, input logic wr, input logic [15:0] ad,
			input logic [6:0] pg);
		logic [31:0] e;
		logic [15:0] wd;
		int          n;
		e = exp_lat(sp, wr, ad, pg);
		wd = 16'($random(seed));
		n = 0;
		@(posedge aclk);
		acc_valid <= 1'h1;
		acc_space <= sp;
		acc_write <= wr;
		acc_addr <= ad;
		acc_page <= pg;
		acc_wdata <= wd;
		do begin
			@(negedge aclk);
			n++;
		end while (acc_ready !== 1'h1);
		check("latency", n, e);
		check("io strobe", io_n, sp != 2'h2);
		check("address", ext_addr, ad);
		check("drive enable", pins_oe, wr);
		if (wr) check("write data", pins_out, wd);
		if (sp == 2'h2) check("select", select, grant_b);
		check("memory strobe", strobe_n, sp == 2'h2);
		check("write line", ext_write, wr);
		@(posedge aclk);
		acc_valid <= 1'h0;
		prev_ok = 1'h1;
		prev_sp = sp;
		prev_wr = wr;
		prev_ad = ad;
		prev_pg = pg;
		// The holder takes the driven word in the edge that ends the transfer.
		@(negedge aclk);
		if (wr) check("holder level", holder_level, wd);
	endtask : access

	task automatic final_report;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	// Main sequence.
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rd_chk(bank_switch_pkg::OFS_CTRL_A, 32'h0000F800, 2'h0);
		rd_chk(bank_switch_pkg::OFS_CTRL_B, 32'h0000F800, 2'h0);
		rd_chk(bank_switch_pkg::OFS_IRQ_STATUS, 32'h0, 2'h0);
		check("holder at reset", holder_en, 1'h0);
		check("lock at reset", lock_a, 1'h0);
		// Random traffic with random bank masks, gap bit and arbitration.
		for (int i = 0; i < 60; i++) begin
			if (i % 10 == 0) begin
				g = 1'($random(seed));
				grant_b <= g;
				wr_ctrl(g, {(i == 50) ? 4'h0 : 4'($random(seed)), 1'($random(seed)), 11'h0});
			end
			access({1'h0, 1'($random(seed))}, 1'($random(seed)), {2'h0, 14'($random(seed))},
				7'($random(seed) & 1));
		end
		access(2'h2, 1'h1, 16'($random(seed)), 7'h00);
		access(2'h2, 1'h0, 16'hFFFF, 7'h00);
		// Reserved bits hold zero whatever software writes.
		for (int i = 0; i < 8; i++) begin
			k = $random(seed);
			axi_write(8'(i % 2 * 4), k);
			rd_chk(8'(i % 2 * 4), {16'h0, k[15:0] & 16'hF905}, 2'h0);
		end
		rd_chk(8'h18, 32'h0, bank_switch_pkg::RESP_SLVERR);
		rd_chk(8'h02, 32'h0, bank_switch_pkg::RESP_SLVERR);
		axi_write(8'h18, 32'hFFFFFFFF);
		check("unmapped write", resp, bank_switch_pkg::RESP_SLVERR);
		grant_b <= 1'h0;
		wr_ctrl(1'h1, 16'hF800);
		wr_ctrl(1'h0, 16'hF800);
		axi_write(bank_switch_pkg::OFS_IRQ_CLEAR, 32'h3);
		rd_chk(bank_switch_pkg::OFS_IRQ_CLEAR, 32'h0, 2'h0);
		// Interprocessor interrupt: set, masked, enabled, cleared, re-armed.
		k = ipi_b;
		ka = ipi_a;
		wr_ctrl(1'h0, 16'hF900);
		rd_chk(bank_switch_pkg::OFS_IRQ_STATUS, 32'h1, 2'h0);
		check("masked irq", irq, 1'h0);
		axi_write(bank_switch_pkg::OFS_IRQ_ENABLE, 32'h3);
		check("irq", irq, 1'h1);
		axi_write(bank_switch_pkg::OFS_IRQ_CLEAR, 32'h1);
		wr_ctrl(1'h0, 16'hF900);
		rd_chk(bank_switch_pkg::OFS_IRQ_STATUS, 32'h0, 2'h0);
		check("pulses to b", ipi_b - k, 32'h1);
		wr_ctrl(1'h0, 16'hF800);
		wr_ctrl(1'h0, 16'hF900);
		wr_ctrl(1'h1, 16'hF900);
		rd_chk(bank_switch_pkg::OFS_IRQ_STATUS, 32'h3, 2'h0);
		check("pulses to b again", ipi_b - k, 32'h2);
		check("pulses to a", ipi_a - ka, 32'h1);
		check("irq again", irq, 1'h1);
		axi_write(bank_switch_pkg::OFS_IRQ_CLEAR, 32'h3);
		check("irq cleared", irq, 1'h0);
		// Bus off in the governing copy stalls requests and raises lock_a.
		wr_ctrl(1'h0, 16'hF801);
		check("lock a", lock_a, 1'h1);
		@(posedge aclk);
		acc_valid <= 1'h1;
		k = 0;
		repeat (8) begin
			@(negedge aclk);
			k += (acc_ready !== 1'h0);
			check("pins idle", strobe_n & io_n, 1'h1);
		end
		check("stalled ready", k, 32'h0);
		@(posedge aclk);
		acc_valid <= 1'h0;
		// The idle copy does not govern the interface.
		wr_ctrl(1'h1, 16'hF805);
		wr_ctrl(1'h0, 16'hF800);
		check("lock b", lock_b, 1'h1);
		access(2'h1, 1'h1, 16'h0123, 7'h00);
		check("holder a", holder_en, 1'h0);
		grant_b <= 1'h1;
		repeat (3) @(negedge aclk);
		check("holder b", holder_en, 1'h1);
		final_report();
	end
endmodule : bank_switch_bus_control_tb_top

// *** tb/ext_bus_model.sv ***
// Behavioural external memory and I/O device on the parallel data pins.
`timescale 1ns/100ps
module ext_bus_model (
	input  wire logic        aclk,
	input  wire logic        ext_strobe_n,
	input  wire logic        io_space_strobe_n,
	input  wire logic        ext_write,
	input  wire logic [15:0] ext_addr,
	output logic      [15:0] data_out = 16'h0000
);
	////////////////////////////////////////////////////////////////////////////////
	// A read cycle answers with a word taken from the address.
	// Outside a read the released pins toggle, so stale data never looks valid.
	always @(posedge aclk) begin
		if ((!ext_strobe_n || !io_space_strobe_n) && !ext_write) begin
			data_out <= ext_addr ^ 16'h5A3C;
		end else begin
			data_out <= ~data_out;
		end
	end
endmodule : ext_bus_model
